// [rtl/fcs_pkg.sv]
// Constants for the floating-point control/status register bank.
// Assumes a single processor clock; transfers arrive as one-cycle strobes.
// Summary of operation
// RL1: Fixed field layout of control/status word
// RL2: Register 31 open to all programs
// RL3: Every field writable and read back
// RL4: No defined value after reset; software initialises (here reset clears the word to zero)
// RL5: Compare writes selected condition bit
// RL6: Flush option zeroes denormal results, no unimplemented
// RL7: Denormal source may flush to zero
// RL8: Precise mode: each instruction rewrites cause
// RL9: Five enables; unimplemented cause always traps
// RL10: Trap when enable and cause both set
// RL11: Raised conditions set flags, others kept
// RL12: Only software writes clear flags
// RL13: Code 0 nearest, ties to even
// RL14: Codes 1,2,3: zero, plus, minus infinity
// RL15: Identification: implementation 15:8, revision 7:0
// RL16: Load marks uninterpreted; compute marks format
// RL17: Uninterpreted consumed as format takes that format
// RL18: Format mismatch or unknown source gives unknown
// RL19: Store keeps tag, encoding of unknown undefined
// RL20: Imprecise write of cause also sets flag
// RL21: Trap request is a level while pending
package fcs_pkg;
	// Control register numbers
	localparam logic [4:0] FCS_REG_IDENT = 5'h00;
	localparam logic [4:0] FCS_REG_CSR = 5'h1f;
	// Field positions inside the control/status word
	localparam int FCS_RND_LSB = 0;
	localparam int FCS_FLAG_LSB = 2;
	localparam int FCS_ENA_LSB = 7;
	localparam int FCS_CAUSE_LSB = 12;
	localparam int FCS_UNIMP_BIT = 17;
	localparam int FCS_ZERO_LSB = 18;
	localparam int FCS_CC0_BIT = 23;
	localparam int FCS_FLUSH_BIT = 24;
	localparam int FCS_CCHI_LSB = 25;
	// Bits that always read zero (22:18)
	localparam logic [31:0] FCS_WRITE_MASK = 32'hff83_ffff;
	// Identification fields, values arbitrary
	localparam logic [7:0] FCS_IMPL_CODE = 8'h5a;
	localparam logic [7:0] FCS_REV_CODE = 8'h01;
	// Rounding codes
	localparam logic [1:0] FCS_RND_NEAREST = 2'h0;
	localparam logic [1:0] FCS_RND_ZERO = 2'h1;
	localparam logic [1:0] FCS_RND_PLUS = 2'h2;
	localparam logic [1:0] FCS_RND_MINUS = 2'h3;
	// Operand register format tags
	typedef enum logic [2:0] {
		FCS_FMT_UNINTERP = 3'h0,
		FCS_FMT_SINGLE = 3'h1,
		FCS_FMT_DOUBLE = 3'h2,
		FCS_FMT_WORD = 3'h3,
		FCS_FMT_LONG = 3'h4,
		FCS_FMT_UNKNOWN = 3'h7
	} fcs_fmt_type;
	localparam int FCS_NUM_OPREGS = 32;
endpackage

// [rtl/fcs_regs.sv]
// Control/status bank and operand format tracking of the floating-point unit.
// Assumes the core issues move-to/move-from strobes and the datapath reports
// completion with exception conditions; everything is on one clock.
`timescale 1ns/1ps
`default_nettype none
module fcs_regs (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Control register transfers from the integer core
	input wire logic ctl_wr,
	input wire logic ctl_rd,
	input wire logic [4:0] ctl_num,
	input wire logic [31:0] ctl_wdata,
	output logic [31:0] ctl_rdata,
	// Mode strap: imprecise exception mode
	input wire logic imprecise_mode,
	// Arithmetic completion from the datapath
	input wire logic arith_done,
	input wire logic [5:0] arith_cause,
	input wire logic arith_denorm_result,
	// Compare result
	input wire logic cmp_done,
	input wire logic [2:0] cmp_sel,
	input wire logic cmp_result,
	// Branch condition test
	input wire logic [2:0] br_sel,
	output logic br_cond,
	// Settings to the datapath
	output logic [1:0] rounding_select,
	output logic flush_denormals,
	output logic flush_source_denormals,
	output logic replace_result_zero,
	// Trap request to the exception logic
	output logic trap_req,
	// Operand register format tracking
	input wire logic load_wr,
	input wire logic [4:0] load_reg,
	input wire logic res_wr,
	input wire logic [4:0] res_reg,
	input wire fcs_pkg::fcs_fmt_type res_fmt,
	input wire logic src_use,
	input wire logic [4:0] src_reg,
	input wire fcs_pkg::fcs_fmt_type src_fmt,
	output logic src_unknown,
	input wire logic [4:0] store_reg,
	output logic store_defined
);
	import fcs_pkg::*;

	logic [31:0] csr_q;
	logic [31:0] csr_d;
	logic [6:0] cc_hi;
	logic [7:0] cc_all;
	logic [4:0] ena;
	logic [5:0] cause;
	logic [5:0] eff_cause;
	logic arith_trap;
	logic csr_wr;
	fcs_fmt_type tag_q [FCS_NUM_OPREGS];

	// Trap decode shared by the completion path and the held word
	function automatic logic fcs_trap_of(input logic [5:0] c, input logic [4:0] e);
		return c[5] || (|(c[4:0] & e));
	endfunction

	// Field views of the held word
	assign cc_hi = csr_q[FCS_CCHI_LSB +: 7];
	assign cc_all = {cc_hi, csr_q[FCS_CC0_BIT]}; // [RL5]
	assign ena = csr_q[FCS_ENA_LSB +: 5];
	assign cause = csr_q[FCS_CAUSE_LSB +: 6];
	assign csr_wr = ctl_wr && (ctl_num == FCS_REG_CSR); // [RL2]

	// Denormal result becomes zero under flush, so unimplemented is dropped
	always_comb begin
		eff_cause = arith_cause;
		if (csr_q[FCS_FLUSH_BIT] && arith_denorm_result) begin
			eff_cause[5] = 1'b0; // [RL6]
		end
	end

	// Precise mode: an enabled condition traps and leaves flags untouched
	assign arith_trap = fcs_trap_of(eff_cause, ena);

	// Next value of the control/status word; write port beats datapath
	always_comb begin
		csr_d = csr_q;
		if (csr_wr) begin
			csr_d = ctl_wdata & FCS_WRITE_MASK; // [RL1] [RL3] [RL12]
			if (imprecise_mode) begin
				csr_d[FCS_FLAG_LSB +: 5] = ctl_wdata[FCS_FLAG_LSB +: 5]
					| ctl_wdata[FCS_CAUSE_LSB +: 5]; // [RL20]
			end
		end else begin
			if (arith_done) begin
				csr_d[FCS_CAUSE_LSB +: 6] = eff_cause; // [RL8]
				if (imprecise_mode || !arith_trap) begin
					csr_d[FCS_FLAG_LSB +: 5] = csr_q[FCS_FLAG_LSB +: 5]
						| eff_cause[4:0]; // [RL11] [RL12]
				end
			end
			if (cmp_done) begin
				if (cmp_sel == 3'h0) begin
					csr_d[FCS_CC0_BIT] = cmp_result; // [RL5]
				end else begin
					csr_d[FCS_CCHI_LSB + int'(cmp_sel) - 1] = cmp_result;
				end
			end
		end
	end

	// Held word; reset clears it to zero
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			csr_q <= 32'h0000_0000; // [RL4]
		end else begin
			csr_q <= csr_d;
		end
	end

	// Trap level while any enabled or unimplemented cause stays set
	assign trap_req = fcs_trap_of(cause, ena); // [RL9] [RL10] [RL21]

	// Read data register
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			ctl_rdata <= 32'h0000_0000;
		end else if (ctl_rd) begin
			case (ctl_num)
				FCS_REG_IDENT: ctl_rdata <= {16'h0000, FCS_IMPL_CODE, FCS_REV_CODE}; // [RL15]
				FCS_REG_CSR: ctl_rdata <= csr_q; // [RL3]
				default: ctl_rdata <= 32'h0000_0000;
			endcase
		end
	end

	// Settings for the arithmetic path
	assign rounding_select = csr_q[FCS_RND_LSB +: 2]; // [RL13] [RL14]
	assign flush_denormals = csr_q[FCS_FLUSH_BIT];
	assign flush_source_denormals = csr_q[FCS_FLUSH_BIT]; // [RL7]
	assign replace_result_zero = csr_q[FCS_FLUSH_BIT] && arith_denorm_result; // [RL6]
	assign br_cond = cc_all[br_sel]; // [RL5]

	// Format tags of the operand registers, one per register
	genvar gi;
	generate
		for (gi = 0; gi < FCS_NUM_OPREGS; gi++) begin : g_tag
			always_ff @(posedge clk or posedge reset) begin
				if (reset) begin
					tag_q[gi] <= FCS_FMT_UNINTERP;
				end else if (res_wr && res_reg == 5'(gi)) begin
					tag_q[gi] <= res_fmt; // [RL16]
				end else if (load_wr && load_reg == 5'(gi)) begin
					tag_q[gi] <= FCS_FMT_UNINTERP; // [RL16]
				end else if (src_use && src_reg == 5'(gi)) begin
					if (tag_q[gi] == FCS_FMT_UNINTERP) begin
						tag_q[gi] <= src_fmt; // [RL17]
					end else if (tag_q[gi] != src_fmt) begin
						tag_q[gi] <= FCS_FMT_UNKNOWN; // [RL18]
					end
				end
			end
		end
	endgenerate

	// Source check and store validity; store never changes the tag
	assign src_unknown = src_use && (tag_q[src_reg] == FCS_FMT_UNKNOWN
		|| (tag_q[src_reg] != FCS_FMT_UNINTERP && tag_q[src_reg] != src_fmt)); // [RL18]
	assign store_defined = tag_q[store_reg] != FCS_FMT_UNKNOWN; // [RL19]
endmodule // fcs_regs
`default_nettype wire

// [verification/fcs_assertions.sv]
// Port checks bound into fcs_regs.
// Assumes one clock, async reset.
`timescale 1ns/1ps
`default_nettype none
module fcs_assertions import fcs_pkg::*; (
	input wire logic clk, reset, ctl_wr, ctl_rd, arith_done, cmp_done, cmp_result, br_cond,
	input wire logic flush_denormals, arith_denorm_result, replace_result_zero, trap_req,
	input wire logic [4:0] ctl_num,
	input wire logic [31:0] ctl_wdata, ctl_rdata,
	input wire logic [2:0] cmp_sel, br_sel,
	input wire logic [1:0] rounding_select
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// Write aimed at the status word
	wire logic w = ctl_wr && ctl_num == FCS_REG_CSR;
	chk_round_write: assert property (w |=>
		rounding_select == $past(ctl_wdata[1:0])) else $error("round");
	chk_flush_write: assert property (w |=>
		flush_denormals == $past(ctl_wdata[24])) else $error("flush");
	chk_trap_write: assert property (w |=> trap_req == ($past(ctl_wdata[17]) ||
		($past(ctl_wdata[16:12]) & $past(ctl_wdata[11:7])) != 5'h00)) else $error("trap");
	chk_other_ignored: assert property (ctl_wr && !w && !arith_done |=>
		$stable(rounding_select) && $stable(trap_req)) else $error("ignored");
	chk_zero_replace: assert property (
		replace_result_zero == (flush_denormals && arith_denorm_result)) else $error("zero");
	chk_cmp_branch: assert property (cmp_done && !ctl_wr |=>
		br_sel != $past(cmp_sel) || br_cond == $past(cmp_result)) else $error("cond");
	chk_ident_read: assert property (ctl_rd && ctl_num == FCS_REG_IDENT |=>
		ctl_rdata[15:0] == {FCS_IMPL_CODE, FCS_REV_CODE}) else $error("ident");
	chk_trap_level: assert property (trap_req && !ctl_wr && !arith_done |=> trap_req)
		else $error("level");
	cover property (w ##1 trap_req);
	cover property (cmp_done ##1 br_cond);
	cover property (arith_done && replace_result_zero);
endmodule // fcs_assertions
bind fcs_regs fcs_assertions u_fcs_assertions (.*);
`default_nettype wire

// [verification/fcs_core.sv]
// Core and datapath model driving fcs_regs.
// Assumes the bench calls its tasks.
`timescale 1ns/1ps
`default_nettype none
module fcs_core (
	input wire logic clk,
	input wire logic [31:0] ctl_rdata,
	output logic ctl_wr, ctl_rd, arith_done, arith_denorm_result, cmp_done, cmp_result,
	output logic [4:0] ctl_num,
	output logic [31:0] ctl_wdata,
	output logic [5:0] arith_cause,
	output logic [2:0] cmp_sel
);
	initial {ctl_wr, ctl_rd, arith_done, arith_denorm_result, cmp_done, cmp_result} = '0;
	initial {ctl_num, ctl_wdata, arith_cause, cmp_sel} = '0;
	// One-cycle strobes; released write data is inverted so stale values never match
	task automatic wr(input logic [4:0] n, input logic [31:0] d);
		@(negedge clk) {ctl_wr, ctl_num, ctl_wdata} = {1'b1, n, d};
		@(negedge clk) {ctl_wr, ctl_wdata} = {1'b0, ~d};
	endtask
	task automatic rd(input logic [4:0] n, output logic [31:0] d);
		@(negedge clk) {ctl_rd, ctl_num} = {1'b1, n};
		@(negedge clk) ctl_rd = 1'b0;
		d = ctl_rdata;
	endtask
	task automatic ar(input logic [5:0] c, input logic z);
		@(negedge clk) {arith_done, arith_cause, arith_denorm_result} = {1'b1, c, z};
		@(negedge clk) {arith_done, arith_denorm_result} = 2'b00;
	endtask
	task automatic cm(input logic [2:0] s, input logic r);
		@(negedge clk) {cmp_done, cmp_sel, cmp_result} = {1'b1, s, r};
		@(negedge clk) cmp_done = 1'b0;
	endtask
endmodule // fcs_core
`default_nettype wire

// [verification/testbench.sv]
// Bench for fcs_regs with a core model.
// Assumes inputs move on falling edges.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import fcs_pkg::*;
	logic clk = 1'b0, reset = 1'b1, imprecise_mode = 1'b0, load_wr = 1'b0, res_wr = 1'b0;
	logic src_use = 1'b0, ctl_wr, ctl_rd, arith_done, arith_denorm_result, cmp_done, cmp_result;
	logic br_cond, flush_denormals, replace_result_zero, trap_req, src_unknown, store_defined;
	logic [4:0] ctl_num, load_reg = 5'h03, res_reg = 5'h03, src_reg = 5'h03, store_reg = 5'h03;
	logic [31:0] ctl_wdata, ctl_rdata, v;
	logic [5:0] arith_cause;
	logic [2:0] cmp_sel, br_sel = 3'h3;
	logic [1:0] rounding_select;
	fcs_fmt_type res_fmt = FCS_FMT_DOUBLE, src_fmt = FCS_FMT_SINGLE;
	int failures = 0, checks = 0;
	// Word written, trap level expected
	logic [32:0] rows [4] = '{{32'hffff_ffff, 1'b1}, {32'h0001_0800, 1'b1},
		{32'h0001_0400, 1'b0}, {32'h0002_0000, 1'b1}};
	always #4 clk = ~clk;
	fcs_regs u_fcs_regs (.*, .flush_source_denormals());
	fcs_core m (.*);
	task automatic compare(input string n, input logic [31:0] e, g);
		checks++;
		if (g !== e) begin
			failures++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic conclude;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	// Tests need about 65 cycles; wide margin
	initial begin
		#8000 failures++;
		conclude();
	end
	initial begin
		repeat (12) @(posedge clk);
		@(negedge clk) reset = 1'b0;
		foreach (rows[i]) begin
			m.wr(FCS_REG_CSR, rows[i][32:1]);
			m.rd(FCS_REG_CSR, v);
			compare("csr", rows[i][32:1] & FCS_WRITE_MASK, v);
			compare("trap", 32'(rows[i][0]), 32'(trap_req));
			compare("round", 32'(rows[i][2:1]), 32'(rounding_select));
		end
		$display("table done");
		m.wr(FCS_REG_CSR, 32'h0);
		m.wr(5'h05, 32'hffff_ffff);
		m.rd(FCS_REG_IDENT, v);
		compare("ident", {16'h0000, FCS_IMPL_CODE, FCS_REV_CODE}, v & 32'h0000_ffff);
		m.ar(6'h03, 1'b0);
		m.ar(6'h10, 1'b0);
		m.rd(FCS_REG_CSR, v);
		compare("sticky", 32'h0001_004c, v);
		m.wr(FCS_REG_CSR, 32'h0100_0000);
		m.ar(6'h20, 1'b1);
		m.cm(3'h0, 1'b1);
		m.cm(3'h3, 1'b1);
		m.rd(FCS_REG_CSR, v);
		compare("flush cc", 32'h0980_0000, v);
		compare("branch", 32'h1, 32'(br_cond));
		compare("flush", 32'h1, 32'(flush_denormals));
		imprecise_mode = 1'b1;
		m.wr(FCS_REG_CSR, 32'h0001_0000);
		m.rd(FCS_REG_CSR, v);
		compare("imprecise", 32'h0001_0040, v);
		$display("ops done");
		@(negedge clk) load_wr = 1'b1;
		@(negedge clk) {load_wr, src_use} = 2'b01;
		#1 compare("fresh", 32'h0, 32'(src_unknown));
		@(negedge clk) src_fmt = FCS_FMT_DOUBLE;
		#1 compare("mismatch", 32'h1, 32'(src_unknown));
		@(negedge clk) {src_use, res_wr} = 2'b01;
		compare("store", 32'h0, 32'(store_defined));
		@(negedge clk) res_wr = 1'b0;
		compare("computed", 32'h1, 32'(store_defined));
		$display("formats done");
		// Mid-run reset brings the word back to zero
		@(negedge clk) reset = 1'b1;
		@(negedge clk) reset = 1'b0;
		m.rd(FCS_REG_CSR, v);
		compare("reset csr", 32'h0, v);
		compare("reset trap", 32'h0, 32'(trap_req));
		$display("reset done");
		conclude();
	end
endmodule // testbench
`default_nettype wire
